/* cbds_pkg.sv */
// Notes on behaviour
// [RULE1] enable high: all outputs actively driven
// [RULE2] enable low: outputs off, dividers held cleared
// [RULE3] enable acts on every output together; osc_out is not gated by the enable
// [RULE4] loop select: PLL clock or bypass reference
// [RULE5] source select high picks oscillator reference
// [RULE6] input select picks first or second input
// [RULE7] predivide select: VCO undivided or halved
// [RULE8] independent divider per bank and feedback
// [RULE9] three-bit select sets feedback ratio
// [RULE10] polarity select inverts bank C outputs 2,3
// [RULE11] sync low one fast period before coincidence
// [RULE12] sync high again at coincident rising edges
// [RULE13] four identical copies per bank, 2-bit selects
// [RULE14] floating selects read as one
// [RULE15] freeze data shifted in on freeze clock
// [RULE16] bank ratio tables for A, B, C
// [RULE17] feedback ratios 4,6,8,10,8,12,16,20
// [RULE18] polarity low plain, high inverts both
// [RULE19] all dividers count on one VCO clock
// [RULE20] dividers restart together after reset release
package cbds_pkg;

  localparam int DIV_W = 5;
  typedef logic [DIV_W-1:0] cbds_div_type;

  // counter value that makes the next tick a rising edge
  localparam cbds_div_type DIV_CLEAR = 5'h1f;

  localparam cbds_div_type RATIO_2 = 5'h02;
  localparam cbds_div_type RATIO_4 = 5'h04;
  localparam cbds_div_type RATIO_6 = 5'h06;
  localparam cbds_div_type RATIO_8 = 5'h08;
  localparam cbds_div_type RATIO_10 = 5'h0a;
  localparam cbds_div_type RATIO_12 = 5'h0c;
  localparam cbds_div_type RATIO_16 = 5'h10;
  localparam cbds_div_type RATIO_20 = 5'h14;

  // register byte offsets
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] CFG_OFF = 4'h4;
  localparam logic [3:0] STAT_OFF = 4'h8;
  localparam logic [3:0] FRZ_OFF = 4'hc;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control register fields
  localparam int CTRL_OVR = 0;
  localparam int CTRL_HOLD = 1;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;

  // configuration field layout, shared by the register and the pin vector
  localparam int CFG_W = 14;
  localparam int CFG_A = 0;
  localparam int CFG_B = 2;
  localparam int CFG_C = 4;
  localparam int CFG_FB = 6;
  localparam int CFG_INV = 9;
  localparam int CFG_VCO = 10;
  localparam int CFG_PLL = 11;
  localparam int CFG_REF = 12;
  localparam int CFG_CLK = 13;
  localparam logic [CFG_W-1:0] CFG_RESET = 14'h3fff;

  // status register fields above the effective configuration
  localparam int STAT_OE = 16;
  localparam int STAT_SYNC = 17;
  localparam int STAT_A = 18;
  localparam int STAT_C = 19;

  // pin vector layout
  localparam int PIN_OE = 0;
  localparam int PIN_FCLK = 1;
  localparam int PIN_FDAT = 2;
  localparam int PIN_REF_A = 3;
  localparam int PIN_REF_B = 4;
  localparam int PIN_OSC = 5;
  localparam int PIN_CFG = 6;
  localparam int PIN_W = PIN_CFG + CFG_W;
  localparam logic [PIN_W-1:0] PIN_RESET = 20'hfffff;

  function automatic cbds_div_type div_next(input cbds_div_type cnt, input cbds_div_type n);
    div_next = (cnt >= n - 5'h01) ? 5'h00 : cnt + 5'h01;
  endfunction

  function automatic cbds_div_type ratio_a(input logic [1:0] sel);
    unique case (sel)
      2'h0: ratio_a = RATIO_4;
      2'h1: ratio_a = RATIO_6;
      2'h2: ratio_a = RATIO_8;
      2'h3: ratio_a = RATIO_12;
    endcase
  endfunction

  function automatic cbds_div_type ratio_b(input logic [1:0] sel);
    unique case (sel)
      2'h0: ratio_b = RATIO_4;
      2'h1: ratio_b = RATIO_6;
      2'h2: ratio_b = RATIO_8;
      2'h3: ratio_b = RATIO_10;
    endcase
  endfunction

  function automatic cbds_div_type ratio_c(input logic [1:0] sel);
    unique case (sel)
      2'h0: ratio_c = RATIO_2;
      2'h1: ratio_c = RATIO_4;
      2'h2: ratio_c = RATIO_6;
      2'h3: ratio_c = RATIO_8;
    endcase
  endfunction

  function automatic cbds_div_type ratio_fb(input logic [2:0] sel);
    unique case (sel)
      3'h0: ratio_fb = RATIO_4;
      3'h1: ratio_fb = RATIO_6;
      3'h2: ratio_fb = RATIO_8;
      3'h3: ratio_fb = RATIO_10;
      3'h4: ratio_fb = RATIO_8;
      3'h5: ratio_fb = RATIO_12;
      3'h6: ratio_fb = RATIO_16;
      3'h7: ratio_fb = RATIO_20;
    endcase
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    apply_strb = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        apply_strb[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction

endpackage

/* cbds_divider.sv */
`timescale 1ns/10ps
`default_nettype none
module cbds_divider (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic clear,
  input wire cbds_pkg::cbds_div_type ratio,
  output cbds_pkg::cbds_div_type cnt_q,
  output logic clk_out_q
);

  cbds_pkg::cbds_div_type cnt_d;

  assign cnt_d = cbds_pkg::div_next(cnt_q, ratio);

  // [RULE2] counter held cleared
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      cnt_q <= cbds_pkg::DIV_CLEAR;
    end else if (tick) begin
      cnt_q <= cnt_d;
    end
  end

  // [RULE20] first tick rises
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      clk_out_q <= 1'b0;
    end else if (tick) begin
      clk_out_q <= (cnt_d < (ratio >> 1));
    end
  end

endmodule
`default_nettype wire

/* cbds_coinc.sv */
`timescale 1ns/10ps
`default_nettype none
module cbds_coinc (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic clear,
  input wire cbds_pkg::cbds_div_type cnt_a,
  input wire cbds_pkg::cbds_div_type cnt_c,
  input wire cbds_pkg::cbds_div_type ratio_a,
  input wire cbds_pkg::cbds_div_type ratio_c,
  output logic sync_q
);

  cbds_pkg::cbds_div_type next_a;
  cbds_pkg::cbds_div_type next_c;
  cbds_pkg::cbds_div_type next_f;
  cbds_pkg::cbds_div_type next_s;
  cbds_pkg::cbds_div_type n_f;
  cbds_pkg::cbds_div_type n_s;
  logic both_rise;
  logic warn;

  assign next_a = cbds_pkg::div_next(cnt_a, ratio_a);
  assign next_c = cbds_pkg::div_next(cnt_c, ratio_c);
  // pick the faster bank
  assign n_f = (ratio_c <= ratio_a) ? ratio_c : ratio_a;
  assign n_s = (ratio_c <= ratio_a) ? ratio_a : ratio_c;
  assign next_f = (ratio_c <= ratio_a) ? next_c : next_a;
  assign next_s = (ratio_c <= ratio_a) ? next_a : next_c;
  assign both_rise = (next_a == 5'h00) && (next_c == 5'h00);
  // faster bank rises now and its next rise meets the slower one
  assign warn = (next_f == 5'h00) && (next_s != 5'h00) && ((n_s - next_s) == n_f);

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      sync_q <= 1'b1;
    end else if (tick) begin
      // [RULE12] high on coincidence
      if (both_rise) begin
        sync_q <= 1'b1;
      // [RULE11] low one period ahead
      end else if (warn) begin
        sync_q <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* cbds_top.sv */
`timescale 1ns/10ps
`default_nettype none
module cbds_top #(
  parameter int ADDR_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reset_n_output_enable,
  input wire logic freeze_shift_clock,
  input wire logic freeze_shift_data,
  input wire logic [2:0] fb_div_sel,
  input wire logic [1:0] bank_a_div_sel,
  input wire logic [1:0] bank_b_div_sel,
  input wire logic [1:0] bank_c_div_sel,
  input wire logic bank_c_invert_select,
  input wire logic vco_predivide_select,
  input wire logic pll_select,
  input wire logic ref_source_select,
  input wire logic ref_input_select,
  input wire logic ref_in_a,
  input wire logic ref_in_b,
  input wire logic osc_in,
  output logic osc_out,
  output logic [3:0] bank_a_out,
  output logic [3:0] bank_b_out,
  output logic [3:0] bank_c_out,
  output logic feedback_out,
  output logic coincidence_sync_out,
  output logic outputs_oe
);

  if (ADDR_W < 4) begin : g_addr_check
    $error("cbds_top needs ADDR_W of at least 4");
  end

  logic [cbds_pkg::PIN_W-1:0] pins;
  logic [cbds_pkg::PIN_W-1:0] pin_s1_q;
  logic [cbds_pkg::PIN_W-1:0] pin_s2_q;
  logic [cbds_pkg::PIN_W-1:0] pin_s3_q;
  logic [cbds_pkg::PIN_W-1:0] pin_f_q;

  logic [31:0] ctrl_q;
  logic [cbds_pkg::CFG_W-1:0] cfg_q;
  logic [cbds_pkg::CFG_W-1:0] cfg_eff;
  logic [31:0] frz_q;
  logic freeze_shift_clock_prev_q;

  logic oe_eff;
  logic clear;
  logic vco_half_q;
  logic pre_tick;
  logic ref_level;
  logic ref_prev_q;
  logic ref_edge;
  logic tick;

  cbds_pkg::cbds_div_type n_a;
  cbds_pkg::cbds_div_type n_b;
  cbds_pkg::cbds_div_type n_c;
  cbds_pkg::cbds_div_type n_fb;
  cbds_pkg::cbds_div_type cnt_a;
  cbds_pkg::cbds_div_type cnt_c;
  logic clk_a;
  logic clk_b;
  logic clk_c;
  logic clk_fb;
  logic sync_raw;

  logic aw_full_q;
  logic w_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic wr_ctrl;
  logic wr_cfg;
  logic wr_ro;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [31:0] cfg_wr;

  // pin gathering; the pin vector layout matches the configuration layout
  assign pins = {ref_input_select, ref_source_select, pll_select, vco_predivide_select,
                 bank_c_invert_select, fb_div_sel, bank_c_div_sel, bank_b_div_sel,
                 bank_a_div_sel, osc_in, ref_in_b, ref_in_a, freeze_shift_data,
                 freeze_shift_clock, reset_n_output_enable};

  // [RULE14] synchronisers idle at one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= cbds_pkg::PIN_RESET;
      pin_s2_q <= cbds_pkg::PIN_RESET;
      pin_s3_q <= cbds_pkg::PIN_RESET;
    end else begin
      pin_s1_q <= pins;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_f_q <= cbds_pkg::PIN_RESET;
    end else begin
      for (int i = 0; i < cbds_pkg::PIN_W; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_f_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  assign cfg_eff = ctrl_q[cbds_pkg::CTRL_OVR] ? cfg_q
                                              : pin_f_q[cbds_pkg::PIN_CFG +: cbds_pkg::CFG_W];

  // [RULE3] one enable for every output except osc_out
  assign oe_eff = pin_f_q[cbds_pkg::PIN_OE] && !ctrl_q[cbds_pkg::CTRL_HOLD];
  // [RULE2] dividers cleared while disabled
  assign clear = !oe_eff;

  // [RULE19] VCO modelled by aclk
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      vco_half_q <= 1'b1;
    end else begin
      vco_half_q <= !vco_half_q;
    end
  end

  // [RULE7] VCO undivided or halved
  assign pre_tick = cfg_eff[cbds_pkg::CFG_VCO] ? 1'b1 : vco_half_q;

  // [RULE5] oscillator or input pin
  // [RULE6] first or second input
  assign ref_level = cfg_eff[cbds_pkg::CFG_REF] ? pin_f_q[cbds_pkg::PIN_OSC] :
                     cfg_eff[cbds_pkg::CFG_CLK] ? pin_f_q[cbds_pkg::PIN_REF_B] :
                                                 pin_f_q[cbds_pkg::PIN_REF_A];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_prev_q <= 1'b1;
    end else begin
      ref_prev_q <= ref_level;
    end
  end

  assign ref_edge = ref_level && !ref_prev_q;

  // [RULE4] PLL path or bypass
  assign tick = cfg_eff[cbds_pkg::CFG_PLL] ? pre_tick : ref_edge;

  // [RULE16] bank ratio decode
  assign n_a = cbds_pkg::ratio_a(cfg_eff[cbds_pkg::CFG_A +: 2]);
  assign n_b = cbds_pkg::ratio_b(cfg_eff[cbds_pkg::CFG_B +: 2]);
  assign n_c = cbds_pkg::ratio_c(cfg_eff[cbds_pkg::CFG_C +: 2]);
  // [RULE9] feedback ratio select
  // [RULE17] feedback ratio decode
  assign n_fb = cbds_pkg::ratio_fb(cfg_eff[cbds_pkg::CFG_FB +: 3]);

  // [RULE8] one divider per bank
  cbds_divider u_div_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .clear(clear),
    .ratio(n_a),
    .cnt_q(cnt_a),
    .clk_out_q(clk_a)
  );

  cbds_divider u_div_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .clear(clear),
    .ratio(n_b),
    .cnt_q(),
    .clk_out_q(clk_b)
  );

  cbds_divider u_div_c (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .clear(clear),
    .ratio(n_c),
    .cnt_q(cnt_c),
    .clk_out_q(clk_c)
  );

  cbds_divider u_div_fb (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .clear(clear),
    .ratio(n_fb),
    .cnt_q(),
    .clk_out_q(clk_fb)
  );

  cbds_coinc u_coinc (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .clear(clear),
    .cnt_a(cnt_a),
    .cnt_c(cnt_c),
    .ratio_a(n_a),
    .ratio_c(n_c),
    .sync_q(sync_raw)
  );

  // [RULE1] outputs driven while enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      outputs_oe <= 1'b0;
    end else begin
      outputs_oe <= oe_eff;
    end
  end

  // one register stage keeps all outputs aligned
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      bank_a_out <= 4'h0;
      bank_b_out <= 4'h0;
      bank_c_out <= 4'h0;
      feedback_out <= 1'b0;
      coincidence_sync_out <= 1'b0;
    end else begin
      // [RULE13] four copies per bank
      bank_a_out <= {4{clk_a}};
      bank_b_out <= {4{clk_b}};
      // [RULE10] invert outputs two and three
      // [RULE18] high level inverts
      bank_c_out <= {{2{clk_c ^ cfg_eff[cbds_pkg::CFG_INV]}}, {2{clk_c}}};
      feedback_out <= clk_fb;
      coincidence_sync_out <= sync_raw;
    end
  end

  // oscillator drive is the inverted input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_out <= 1'b0;
    end else begin
      osc_out <= !pin_f_q[cbds_pkg::PIN_OSC];
    end
  end

  // [RULE15] capture freeze bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freeze_shift_clock_prev_q <= 1'b1;
      frz_q <= 32'h00000000;
    end else begin
      freeze_shift_clock_prev_q <= pin_f_q[cbds_pkg::PIN_FCLK];
      if (pin_f_q[cbds_pkg::PIN_FCLK] && !freeze_shift_clock_prev_q) begin
        frz_q <= {frz_q[30:0], pin_f_q[cbds_pkg::PIN_FDAT]};
      end
    end
  end

  // register bus: write address and data are held until both are present
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
  assign wr_ctrl = aw_addr_q[3:0] == cbds_pkg::CTRL_OFF;
  assign wr_cfg = aw_addr_q[3:0] == cbds_pkg::CFG_OFF;
  assign wr_ro = (aw_addr_q[3:0] == cbds_pkg::STAT_OFF) || (aw_addr_q[3:0] == cbds_pkg::FRZ_OFF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && !aw_full_q) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && !w_full_q) begin
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cbds_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_ctrl || wr_cfg || wr_ro) ? cbds_pkg::RESP_OKAY : cbds_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= cbds_pkg::CTRL_RESET;
    end else if (do_write && wr_ctrl) begin
      ctrl_q <= cbds_pkg::apply_strb(ctrl_q, w_data_q, w_strb_q) & 32'h00000003;
    end
  end

  assign cfg_wr = cbds_pkg::apply_strb({18'h00000, cfg_q}, w_data_q, w_strb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= cbds_pkg::CFG_RESET;
    end else if (do_write && wr_cfg) begin
      cfg_q <= cfg_wr[cbds_pkg::CFG_W-1:0];
    end
  end

  // read decode
  always_comb begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr[3:0])
      cbds_pkg::CTRL_OFF: rd_word = ctrl_q;
      cbds_pkg::CFG_OFF: rd_word = {18'h00000, cfg_q};
      cbds_pkg::STAT_OFF: begin
        rd_word[cbds_pkg::CFG_W-1:0] = cfg_eff;
        rd_word[cbds_pkg::STAT_OE] = oe_eff;
        rd_word[cbds_pkg::STAT_SYNC] = sync_raw;
        rd_word[cbds_pkg::STAT_A] = clk_a;
        rd_word[cbds_pkg::STAT_C] = clk_c;
      end
      cbds_pkg::FRZ_OFF: rd_word = frz_q;
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= cbds_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? cbds_pkg::RESP_OKAY : cbds_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* cbds_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module cbds_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic reset_n_output_enable,
  input wire logic bank_c_invert_select,
  input wire logic [3:0] bank_a_out,
  input wire logic [3:0] bank_b_out,
  input wire logic [3:0] bank_c_out,
  input wire logic feedback_out,
  input wire logic coincidence_sync_out,
  input wire logic outputs_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_all_rise;
    $rose(bank_a_out[0]) && $rose(bank_b_out[0]) && $rose(bank_c_out[0]) && $rose(feedback_out);
  endsequence
  sequence s_pin_off;
    !reset_n_output_enable [*8];
  endsequence

  a_copies_alike: assert property (
    (bank_a_out == 4'h0 || bank_a_out == 4'hf) && (bank_b_out == 4'h0 || bank_b_out == 4'hf)
    && bank_c_out[1] == bank_c_out[0] && bank_c_out[3] == bank_c_out[2])
    else $error("bank copies differ");
  a_invert_pair: assert property (
    $stable(bank_c_invert_select) [*8] ##0 outputs_oe
    |-> (bank_c_out[2] ^ bank_c_out[0]) == bank_c_invert_select)
    else $error("bank c upper polarity wrong");
  a_pin_off: assert property (
    s_pin_off |-> !outputs_oe && {bank_a_out, bank_b_out, bank_c_out} == 12'h0
    && !feedback_out && !coincidence_sync_out)
    else $error("outputs not off while enable pin low");
  a_start_aligned: assert property (
    $rose(outputs_oe) |-> ##[0:6] s_all_rise)
    else $error("dividers did not restart together");
  a_sync_rise: assert property (
    $rose(coincidence_sync_out) && $past(outputs_oe, 8)
    |-> $rose(bank_a_out[0]) && $rose(bank_c_out[0]))
    else $error("sync rose away from common edge");
  a_sync_fall: assert property (
    $fell(coincidence_sync_out) && outputs_oe
    |-> $rose(bank_a_out[0]) || $rose(bank_c_out[0]))
    else $error("sync fell away from a bank edge");
  a_wr_answer: assert property (
    s_wr_taken |=> ##1 s_axi_bvalid ##1 !s_axi_bvalid)
    else $error("write response late or repeated");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  a_rd_error: assert property (
    s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("read error carries data");
endmodule

bind cbds_top cbds_checker i_checker (.*);
`default_nettype wire

/* cbds_sink.sv */
`timescale 1ns/10ps
`default_nettype none
module cbds_sink (
  input wire logic aclk,
  input wire logic outputs_oe,
  input wire logic [3:0] bank_a_out,
  input wire logic [3:0] bank_b_out,
  input wire logic [3:0] bank_c_out,
  input wire logic feedback_out,
  input wire logic coincidence_sync_out,
  output int per [5],
  output int lo_len
);
  logic [4:0] seen;
  logic [4:0] pin_q;
  int cnt [5];
  int lo_q;

  // an undriven pin floats low at the loads
  assign seen = outputs_oe ? {coincidence_sync_out, feedback_out, bank_c_out[0],
                              bank_b_out[0], bank_a_out[0]} : 5'h0;

  // rise-to-rise period of each clock, low span of sync
  always @(posedge aclk) begin
    for (int i = 0; i < 5; i++) begin
      if (seen[i] && !pin_q[i]) begin
        per[i] <= cnt[i];
        cnt[i] <= 1;
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
    lo_q <= seen[4] ? 0 : lo_q + 1;
    if (seen[4] && !pin_q[4]) lo_len <= lo_q;
    pin_q <= seen;
  end
endmodule
`default_nettype wire

/* clock_bank_divider_select_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module clock_bank_divider_select_bench;
  logic aclk;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic reset_n_output_enable = 1'b1, freeze_shift_clock = 1'b1, freeze_shift_data = 1'b1;
  logic [2:0] fb_div_sel = 3'h0;
  logic [1:0] bank_a_div_sel = 2'h0, bank_b_div_sel = 2'h0, bank_c_div_sel = 2'h0;
  logic bank_c_invert_select = 1'b0, vco_predivide_select = 1'b1, pll_select = 1'b1;
  logic ref_source_select = 1'b0, ref_input_select = 1'b0;
  logic ref_in_a = 1'b0, ref_in_b = 1'b0, osc_in = 1'b0, osc_out;
  logic [3:0] bank_a_out, bank_b_out, bank_c_out;
  logic feedback_out, coincidence_sync_out, outputs_oe;
  int n_errors = 0, comparisons = 0, tc = 0, lo_len;
  int per [5];
  localparam int ea [4] = '{4, 6, 8, 12};
  localparam int eb [4] = '{4, 6, 8, 10};
  localparam int ec [4] = '{2, 4, 6, 8};
  localparam int ef [8] = '{4, 6, 8, 10, 8, 12, 16, 20};
  localparam int bp [3] = '{32, 48, 64};
  // bit-symmetric, so shift order does not matter
  localparam logic [31:0] frz_word = 32'hf00ff00f;

  cbds_top i_dut (.*);
  cbds_sink i_sink (.*);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // reference periods of 16, 24 and 32 cycles
  always @(posedge aclk) begin
    tc <= tc + 1;
    if (tc % 8 == 0) ref_in_a <= ~ref_in_a;
    if (tc % 12 == 0) ref_in_b <= ~ref_in_b;
    if (tc % 16 == 0) osc_in <= ~osc_in;
  end

  task automatic chk(input string what, input logic [31:0] want, input logic [31:0] seen);
    comparisons++;
    if (seen !== want) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic pulse_oe(input int n);
    reset_n_output_enable <= 1'b0;
    repeat (9) @(posedge aclk);
    reset_n_output_enable <= 1'b1;
    settle(n);
  endtask

  task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] d, output logic [1:0] r);
    logic aw, w, ar, got;
    @(posedge aclk);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= wd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    do begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      ar = s_axi_arvalid && s_axi_arready;
      got = wr ? s_axi_bvalid : s_axi_rvalid;
      r = wr ? s_axi_bresp : s_axi_rresp;
      d = s_axi_rdata;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
    end while (got !== 1'b1);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axi(1'b0, 4'h4, 32'h0, d, r);
    chk("cfg reset", 32'h3fff, d);
    axi(1'b1, 4'h0, 32'h2, d, r);
    chk("hold bresp", 32'h0, {30'h0, r});
    settle(8);
    chk("hold oe", 32'h0, {31'h0, outputs_oe});
    axi(1'b0, 4'h0, 32'h0, d, r);
    chk("ctrl readback", 32'h2, d);
    axi(1'b1, 4'h0, 32'h0, d, r);
    settle(8);
    chk("release oe", 32'h1, {31'h0, outputs_oe});
    axi(1'b1, 4'h2, 32'h1, d, r);
    chk("unmapped bresp", 32'h2, {30'h0, r});
    axi(1'b0, 4'h6, 32'h0, d, r);
    chk("unmapped rresp", 32'h2, {30'h0, r});
    $display("regs done");
  endtask

  task automatic t_freeze;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 31; i >= 0; i--) begin
      @(posedge aclk);
      freeze_shift_data <= frz_word[i];
      freeze_shift_clock <= 1'b0;
      repeat (8) @(posedge aclk);
      freeze_shift_clock <= 1'b1;
      repeat (7) @(posedge aclk);
    end
    axi(1'b0, 4'hc, 32'h0, d, r);
    chk("freeze word", frz_word, d);
    $display("freeze done");
  endtask

  task automatic t_ratios;
    for (int i = 0; i < 9; i++) begin
      int m;
      m = (i < 8) ? 1 : 2;
      @(posedge aclk);
      bank_a_div_sel <= i[1:0];
      bank_b_div_sel <= 2'(i + 1);
      bank_c_div_sel <= 2'(i + 2);
      fb_div_sel <= i[2:0];
      vco_predivide_select <= (i < 8);
      pulse_oe(120);
      chk("bank a period", ea[i % 4] * m, per[0]);
      chk("bank b period", eb[(i + 1) % 4] * m, per[1]);
      chk("bank c period", ec[(i + 2) % 4] * m, per[2]);
      chk("feedback period", ef[i % 8] * m, per[3]);
    end
    @(posedge aclk);
    vco_predivide_select <= 1'b1;
    $display("ratios done");
  endtask

  task automatic t_enable;
    @(posedge aclk);
    reset_n_output_enable <= 1'b0;
    settle(12);
    chk("pin oe low", 32'h0, {31'h0, outputs_oe});
    chk("outputs idle", 32'h0, {18'h0, bank_a_out, bank_b_out, bank_c_out, feedback_out,
                                coincidence_sync_out});
    @(posedge aclk);
    reset_n_output_enable <= 1'b1;
    settle(12);
    chk("pin oe high", 32'h1, {31'h0, outputs_oe});
    $display("enable done");
  endtask

  task automatic t_invert;
    for (int v = 1; v >= 0; v--) begin
      @(posedge aclk);
      bank_c_invert_select <= v[0];
      settle(20);
      repeat (4) begin
        chk("bank c upper", {30'h0, {2{bank_c_out[0] ^ v[0]}}}, {30'h0, bank_c_out[3:2]});
        @(negedge aclk);
      end
    end
    $display("invert done");
  endtask

  task automatic t_sync;
    for (int k = 1; k < 3; k++) begin
      @(posedge aclk);
      bank_a_div_sel <= k[1:0];
      bank_c_div_sel <= k[1:0];
      pulse_oe(150);
      chk("sync low span", ec[k], lo_len);
      chk("sync period", ea[k] * ec[k] / 2, per[4]);
    end
    $display("sync done");
  endtask

  task automatic t_bypass;
    @(posedge aclk);
    bank_c_div_sel <= 2'h0;
    pulse_oe(8);
    for (int k = 0; k < 3; k++) begin
      @(posedge aclk);
      pll_select <= 1'b0;
      ref_source_select <= (k == 2);
      ref_input_select <= (k == 1);
      settle(250);
      chk("bypass c period", bp[k], per[2]);
    end
    $display("bypass done");
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    settle(8);
    t_regs();
    t_freeze();
    t_ratios();
    t_enable();
    t_invert();
    t_sync();
    t_bypass();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    $display("[ERR] run length expected under 20000 cycles seen more");
    wrap_up();
  end
endmodule
`default_nettype wire
